// File: hw/mem_select_pkg.sv
// constants and types for the memory select and flash status block
// How it works
// R1 - every memory select comes from the programmable decode array, never fixed decoding
// R2 - sixteen primary sector selects, one per 64-Kbyte sector
// R3 - four secondary sector selects for 16, 8, 8 and 32 Kbyte sectors
// R4 - each sector select is the OR of up to three product terms
// R5 - the whole SRAM is enabled by one select
// R6 - selects can remap sectors between program and data spaces around in-application update
// R7 - each sector of either flash can be protected on its own
// R8 - erase works on whole sectors, program writes one word per operation
// R9 - sector erase may be suspended, other sectors read, then resumed
// R10 - when enabled, program and erase status drives the ready/busy pin
// R11 - ready/busy is low while any flash is being programmed or erased
// R12 - ready/busy is high when no write or erase is in progress
// R13 - a per-sector protection bit reads one when protected, zero otherwise
// R14 - only address bits 11 to 0 are used for instruction decoding
// R15 - program or erase aimed at a protected sector is ignored
// R16 - decode configuration should keep at most one memory select active per access
package mem_select_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int NUM_PRIMARY = 16;
	localparam int NUM_SECONDARY = 4;
	localparam int NUM_SECTORS = NUM_PRIMARY + NUM_SECONDARY;
	localparam int NUM_TERMS = 3;
	localparam int SECT_W = 5;
	localparam int INSTR_ADDR_MSB = 11;
	// sector sizes in Kbytes
	localparam int PRIMARY_KBYTES = 64;
	localparam int SECONDARY0_KBYTES = 16;
	localparam int SECONDARY1_KBYTES = 8;
	localparam int SECONDARY2_KBYTES = 8;
	localparam int SECONDARY3_KBYTES = 32;
	// embedded operation times
	localparam int CLK_MHZ = 100;
	localparam int PROGRAM_US = 10;
	localparam int ERASE_US = 1000;
	localparam int PROGRAM_CYCLES = PROGRAM_US * CLK_MHZ;
	localparam int ERASE_CYCLES = ERASE_US * CLK_MHZ;
	localparam int CNT_W = 32;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_PROGRAM = 3'h1,
		ST_ERASE = 3'h2,
		ST_SUSPEND = 3'h3
	} flash_state_t;
endpackage : mem_select_pkg

// File: hw/mem_select_flash_status.sv
// memory block select decode and flash program/erase status
`timescale 1ns/1ns
module mem_select_flash_status #(
	parameter int PROGRAM_CNT = mem_select_pkg::PROGRAM_CYCLES,
	parameter int ERASE_CNT = mem_select_pkg::ERASE_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic clk_en_in,
	input wire logic [mem_select_pkg::ADDR_W-1:0] addr_in,
	input wire logic code_space_in,
	input wire logic in_application_update_in,
	// per sector, per term: care mask, match value, space enable (bit0 data, bit1 code; bit2 data, bit3 code during in-application update)
	input wire logic [mem_select_pkg::NUM_SECTORS*mem_select_pkg::NUM_TERMS*mem_select_pkg::ADDR_W-1:0] term_mask_in,
	input wire logic [mem_select_pkg::NUM_SECTORS*mem_select_pkg::NUM_TERMS*mem_select_pkg::ADDR_W-1:0] term_match_in,
	input wire logic [mem_select_pkg::NUM_SECTORS*mem_select_pkg::NUM_TERMS*4-1:0] term_space_in,
	input wire logic [mem_select_pkg::NUM_SECTORS*mem_select_pkg::NUM_TERMS-1:0] term_enable_in,
	input wire logic [mem_select_pkg::ADDR_W-1:0] sram_mask_in,
	input wire logic [mem_select_pkg::ADDR_W-1:0] sram_match_in,
	input wire logic [mem_select_pkg::NUM_SECTORS-1:0] protect_in,
	input wire logic ready_busy_enable_in,
	input wire logic program_req_in,
	input wire logic erase_req_in,
	input wire logic suspend_req_in,
	input wire logic resume_req_in,
	input wire logic [mem_select_pkg::SECT_W-1:0] target_sector_in,
	input wire logic [mem_select_pkg::DATA_W-1:0] program_data_in,
	output logic [mem_select_pkg::NUM_PRIMARY-1:0] primary_sector_select_out,
	output logic [mem_select_pkg::NUM_SECONDARY-1:0] secondary_sector_select_out,
	output logic sram_block_select_out,
	output logic [mem_select_pkg::NUM_SECTORS-1:0] protect_status_out,
	output logic [mem_select_pkg::INSTR_ADDR_MSB:0] instr_addr_out,
	output logic ready_busy_pin_out,
	output logic ready_busy_pin_oe_out,
	output logic busy_out,
	output logic suspended_out,
	output logic write_strobe_out,
	output logic [mem_select_pkg::SECT_W-1:0] active_sector_out,
	output logic [mem_select_pkg::DATA_W-1:0] write_data_out,
	output logic rejected_out
);
	import mem_select_pkg::*;

	// one product term: masked address compare qualified by bus space
	function automatic logic term_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] m,
		input logic [ADDR_W-1:0] v, input logic [3:0] sp, input logic code, input logic in_application_update, input logic en);
		logic space_ok;
		space_ok = in_application_update ? (code ? sp[3] : sp[2]) : (code ? sp[1] : sp[0]);
		term_hit = en && space_ok && ((a & m) == (v & m));
	endfunction : term_hit

	logic [NUM_SECTORS-1:0] sel_ff, nxt_sel;
	logic sram_ff, nxt_sram;
	logic [NUM_SECTORS-1:0] prot_ff, nxt_prot;
	logic [INSTR_ADDR_MSB:0] iaddr_ff, nxt_iaddr;

	always_comb
	begin
		nxt_sel = '0;
		for (int s = 0; s < NUM_SECTORS; s++)
		begin
			for (int t = 0; t < NUM_TERMS; t++)
			begin
				nxt_sel[s] = nxt_sel[s] | term_hit(addr_in, // R1 R4
					term_mask_in[(s*NUM_TERMS+t)*ADDR_W +: ADDR_W],
					term_match_in[(s*NUM_TERMS+t)*ADDR_W +: ADDR_W],
					term_space_in[(s*NUM_TERMS+t)*4 +: 4], // R6
					code_space_in, in_application_update_in,
					term_enable_in[s*NUM_TERMS+t]);
			end
		end
		nxt_sram = ((addr_in & sram_mask_in) == (sram_match_in & sram_mask_in)); // R5
		nxt_prot = protect_in; // R7 R13
		nxt_iaddr = addr_in[INSTR_ADDR_MSB:0]; // R14
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			sel_ff <= '0;
			sram_ff <= 1'b0;
			prot_ff <= '0;
			iaddr_ff <= '0;
		end
		else if (clk_en_in)
		begin
			sel_ff <= nxt_sel;
			sram_ff <= nxt_sram;
			prot_ff <= nxt_prot;
			iaddr_ff <= nxt_iaddr;
		end
	end

	assign primary_sector_select_out = sel_ff[NUM_PRIMARY-1:0]; // R2
	assign secondary_sector_select_out = sel_ff[NUM_SECTORS-1:NUM_PRIMARY]; // R3
	assign sram_block_select_out = sram_ff;
	assign protect_status_out = prot_ff;
	assign instr_addr_out = iaddr_ff;

	// embedded program and erase sequencer
	flash_state_t state_ff, nxt_state;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [SECT_W-1:0] sect_ff, nxt_sect;
	logic [DATA_W-1:0] data_ff, nxt_data;
	logic strobe_ff, nxt_strobe;
	logic rej_ff, nxt_rej;
	logic rb_ff, nxt_rb;
	logic rboe_ff, nxt_rboe;
	logic busy_ff, nxt_busy;
	logic susp_ff, nxt_susp;
	logic target_ok;

	always_comb
	begin
		target_ok = (32'(target_sector_in) < NUM_SECTORS) && !protect_in[target_sector_in]; // R15
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_sect = sect_ff;
		nxt_data = data_ff;
		nxt_strobe = 1'b0;
		nxt_rej = 1'b0;
		unique case (state_ff)
			ST_IDLE:
			begin
				if (program_req_in || erase_req_in)
				begin
					if (target_ok)
					begin
						nxt_sect = target_sector_in;
						nxt_data = program_data_in; // R8
						nxt_state = program_req_in ? ST_PROGRAM : ST_ERASE; // R8
						nxt_cnt = program_req_in ? CNT_W'(PROGRAM_CNT - 1) : CNT_W'(ERASE_CNT - 1);
						nxt_strobe = program_req_in;
					end
					else
					begin
						nxt_rej = 1'b1; // R15
					end
				end
			end
			ST_PROGRAM:
			begin
				if (cnt_ff == '0)
					nxt_state = ST_IDLE;
				else
					nxt_cnt = cnt_ff - 1'b1;
			end
			ST_ERASE:
			begin
				if (suspend_req_in)
					nxt_state = ST_SUSPEND; // R9
				else if (cnt_ff == '0)
					nxt_state = ST_IDLE;
				else
					nxt_cnt = cnt_ff - 1'b1;
			end
			ST_SUSPEND:
			begin
				if (resume_req_in)
					nxt_state = ST_ERASE; // R9
			end
			default:
			begin
				nxt_state = ST_IDLE;
			end
		endcase
		nxt_rb = !((nxt_state == ST_PROGRAM) || (nxt_state == ST_ERASE)); // R11 R12
		nxt_rboe = ready_busy_enable_in; // R10
		// status copies kept in their own flops so every output is registered
		nxt_busy = !nxt_rb; // R11
		nxt_susp = (nxt_state == ST_SUSPEND); // R9
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			state_ff <= ST_IDLE;
			cnt_ff <= '0;
			sect_ff <= '0;
			data_ff <= '0;
			strobe_ff <= 1'b0;
			rej_ff <= 1'b0;
			rb_ff <= 1'b1;
			rboe_ff <= 1'b0;
			busy_ff <= 1'b0;
			susp_ff <= 1'b0;
		end
		else if (clk_en_in)
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			sect_ff <= nxt_sect;
			data_ff <= nxt_data;
			strobe_ff <= nxt_strobe;
			rej_ff <= nxt_rej;
			rb_ff <= nxt_rb;
			rboe_ff <= nxt_rboe;
			busy_ff <= nxt_busy;
			susp_ff <= nxt_susp;
		end
	end

	assign ready_busy_pin_out = rb_ff;
	assign ready_busy_pin_oe_out = rboe_ff;
	assign busy_out = busy_ff;
	assign suspended_out = susp_ff;
	assign write_strobe_out = strobe_ff;
	assign active_sector_out = sect_ff;
	assign write_data_out = data_ff;
	assign rejected_out = rej_ff;

	// checks
	a_busy_low_active: assert property (@(posedge ref_clk_in) disable iff (srst_in) // R11
		(state_ff == ST_PROGRAM || state_ff == ST_ERASE) |-> !ready_busy_pin_out)
		else $error("ready/busy high while flash busy");
	a_ready_high_idle: assert property (@(posedge ref_clk_in) disable iff (srst_in) // R12
		(state_ff == ST_IDLE || state_ff == ST_SUSPEND) |-> ready_busy_pin_out)
		else $error("ready/busy low while idle");
	a_protected_ignored: assert property (@(posedge ref_clk_in) disable iff (srst_in) // R15
		(clk_en_in && state_ff == ST_IDLE && (program_req_in || erase_req_in) && !target_ok)
		|=> (state_ff == ST_IDLE && rejected_out))
		else $error("protected sector request accepted");
	a_suspend_holds: assert property (@(posedge ref_clk_in) disable iff (srst_in) // R9
		(clk_en_in && state_ff == ST_ERASE && suspend_req_in) |=> (suspended_out && $stable(cnt_ff)))
		else $error("erase not suspended");
	a_resume_erase: assert property (@(posedge ref_clk_in) disable iff (srst_in) // R9
		(clk_en_in && state_ff == ST_SUSPEND && resume_req_in) |=> (state_ff == ST_ERASE))
		else $error("erase not resumed");
	a_program_strobe: assert property (@(posedge ref_clk_in) disable iff (srst_in) // R8
		write_strobe_out |-> (state_ff == ST_PROGRAM && write_data_out == $past(program_data_in)))
		else $error("program strobe without program");
	a_sram_select: assert property (@(posedge ref_clk_in) disable iff (srst_in) // R5
		clk_en_in |=> (sram_block_select_out == (($past(addr_in) & $past(sram_mask_in)) ==
		($past(sram_match_in) & $past(sram_mask_in)))))
		else $error("sram select mismatch");
	a_instr_addr: assert property (@(posedge ref_clk_in) disable iff (srst_in) // R14
		clk_en_in |=> (instr_addr_out == $past(addr_in[INSTR_ADDR_MSB:0])))
		else $error("instruction address wrong");
	a_protect_view: assert property (@(posedge ref_clk_in) disable iff (srst_in) // R13
		clk_en_in |=> (protect_status_out == $past(protect_in)))
		else $error("protection status wrong");
	a_pin_enable: assert property (@(posedge ref_clk_in) disable iff (srst_in) // R10
		clk_en_in |=> (ready_busy_pin_oe_out == $past(ready_busy_enable_in)))
		else $error("ready/busy enable wrong");

	// status flops must agree with the sequencer state
	a_busy_inverse: assert property (@(posedge ref_clk_in) disable iff (srst_in) // R11
		busy_out == !ready_busy_pin_out)
		else $error("busy flag disagrees with pin");
	a_suspend_level: assert property (@(posedge ref_clk_in) disable iff (srst_in) // R9
		suspended_out == (state_ff == ST_SUSPEND))
		else $error("suspended flag disagrees with state");
	a_strobe_busy: assert property (@(posedge ref_clk_in) disable iff (srst_in) // R11
		write_strobe_out |-> !ready_busy_pin_out)
		else $error("program strobe while pin ready");
	a_reject_idle: assert property (@(posedge ref_clk_in) disable iff (srst_in) // R15
		rejected_out |-> (state_ff == ST_IDLE && !write_strobe_out))
		else $error("refusal left sequencer running");

	// clock enable low freezes every register
	a_freeze_hold: assert property (@(posedge ref_clk_in) disable iff (srst_in) // R1
		!clk_en_in |=> ($stable(state_ff) && $stable(cnt_ff) && $stable(sel_ff) && $stable(sram_ff)))
		else $error("state moved while clock enable low");
	c_program: cover property (@(posedge ref_clk_in) state_ff == ST_PROGRAM ##1 state_ff == ST_IDLE);
	c_suspend_resume: cover property (@(posedge ref_clk_in) state_ff == ST_SUSPEND ##1 state_ff == ST_ERASE);
	c_rejected: cover property (@(posedge ref_clk_in) rejected_out);
	c_erase_done: cover property (@(posedge ref_clk_in) state_ff == ST_ERASE ##1 state_ff == ST_IDLE);
	c_freeze: cover property (@(posedge ref_clk_in) !clk_en_in && !srst_in);
endmodule : mem_select_flash_status

// File: tb/host_model.sv
// host side model issuing flash requests
`timescale 1ns/1ns
module host_model (
	input wire logic clk_in,
	output logic [3:0] req_out,
	output logic [4:0] sector_out,
	output logic [15:0] data_out
);
	initial
	begin
		req_out = 4'h0;
		sector_out = 5'h1F;
		data_out = 16'hFFFF;
	end
	// k: bit0 program, bit1 erase, bit2 suspend, bit3 resume
	task automatic issue(input logic [3:0] k, input logic [4:0] s, input logic [15:0] d);
		@(negedge clk_in);
		req_out <= k;
		sector_out <= s;
		data_out <= d;
		@(negedge clk_in);
		req_out <= 4'h0;
		sector_out <= ~s;
		data_out <= ~d;
	endtask : issue
endmodule : host_model

// File: tb/mem_select_flash_status_tb.sv
// self-checking bench for the memory select and flash status block
`timescale 1ns/1ns
module mem_select_flash_status_tb;
	import mem_select_pkg::*;
	localparam int PC = 5;
	localparam int EC = 20;
	localparam int NT = NUM_SECTORS * NUM_TERMS;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [ADDR_W-1:0] addr = '0;
	logic code = 1'b0;
	logic in_application_update = 1'b0;
	logic [NT*ADDR_W-1:0] tmask = '0;
	logic [NT*ADDR_W-1:0] tmatch = '0;
	logic [NT*4-1:0] tspace = '0;
	logic [NT-1:0] ten = '0;
	logic [NUM_SECTORS-1:0] prot = '0;
	logic rb_en = 1'b0;
	logic cen = 1'b1;
	logic [3:0] req;
	logic [SECT_W-1:0] tsec;
	logic [DATA_W-1:0] pdata;
	logic [15:0] psel;
	logic [3:0] ssel;
	logic rsel, pin, oe, busy, susp, stb, rej;
	logic [19:0] pstat;
	logic [11:0] iaddr;
	logic [SECT_W-1:0] asec;
	logic [DATA_W-1:0] wdata;
	logic [21:0] q[$];
	logic [21:0] e;
	int mismatches = 0;
	int check_count = 0;
	int low_cnt = 0;
	host_model u_host (.clk_in(clk), .req_out(req), .sector_out(tsec), .data_out(pdata));
	mem_select_flash_status #(.PROGRAM_CNT(PC), .ERASE_CNT(EC)) u_dut (
		.ref_clk_in(clk), .srst_in(srst), .clk_en_in(cen), .addr_in(addr),
		.code_space_in(code), .in_application_update_in(in_application_update),
		.term_mask_in(tmask), .term_match_in(tmatch), .term_space_in(tspace),
		.term_enable_in(ten), .sram_mask_in(24'hFFFFFF), .sram_match_in(24'h000000),
		.protect_in(prot), .ready_busy_enable_in(rb_en),
		.program_req_in(req[0]), .erase_req_in(req[1]), .suspend_req_in(req[2]),
		.resume_req_in(req[3]), .target_sector_in(tsec), .program_data_in(pdata),
		.primary_sector_select_out(psel), .secondary_sector_select_out(ssel),
		.sram_block_select_out(rsel), .protect_status_out(pstat), .instr_addr_out(iaddr),
		.ready_busy_pin_out(pin), .ready_busy_pin_oe_out(oe), .busy_out(busy),
		.suspended_out(susp), .write_strobe_out(stb), .active_sector_out(asec),
		.write_data_out(wdata), .rejected_out(rej));
	task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] g);
		check_count++;
		if (g !== x)
		begin
			mismatches++;
			$display("BAD %s expected %0h seen %0h", nm, x, g);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done
	task automatic dec(input logic [23:0] a, input logic [19:0] x, input logic r);
		addr = a;
		@(negedge clk);
		chk("primary", x[15:0], psel);
		chk("secondary", x[19:16], ssel);
		chk("sram", r, rsel);
		chk("instr_addr", a[11:0], iaddr);
	endtask : dec
	task automatic run(input logic [3:0] k, input logic [4:0] s, input logic r, input int n);
		int c0;
		int i;
		logic [15:0] d;
		c0 = low_cnt;
		d = 16'($urandom);
		if (k == 4'h1 || r)
			q.push_back({r, s, d});
		u_host.issue(k, s, d);
		@(negedge clk);
		for (i = 0; i < 300 && pin !== 1'b1; i++)
			@(negedge clk);
		chk("busy_cycles", n, low_cnt - c0);
	endtask : run
	initial
	begin
		forever #5 clk = ~clk;
	end
	// count busy cycles and match each strobe or refusal against its note
	always @(negedge clk)
	begin
		if (pin === 1'b0)
			low_cnt++;
		if (stb === 1'b1 || rej === 1'b1)
		begin
			chk("pending", 1, q.size() > 0);
			e = (q.size() > 0) ? q.pop_front() : 22'h000000;
			chk("reject", e[21], rej);
			if (!e[21])
				chk("word", e[20:0], {asec, wdata});
		end
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		mismatches++;
		test_done();
	end
	initial
	begin
		int s, t, i;
		logic [7:0] m;
		void'($urandom(76));
		repeat (8) @(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		chk("rst_pin", 1, pin);
		chk("rst_oe", 0, oe);
		chk("rst_busy", 0, busy);
		dec(24'h000000, 20'h00000, 1'b1);
		code = 1'b1;
		for (i = 0; i < 8; i++)
		begin
			s = $urandom % NUM_SECTORS;
			t = $urandom % NUM_TERMS;
			m = 8'h01 + 8'($urandom % 127);
			ten = '0;
			ten[s*3+t] = 1'b1;
			ten[s*3+(t+1)%3] = 1'b1;
			tmask[(s*3+t)*24 +: 24] = 24'hFF0000;
			tmatch[(s*3+t)*24 +: 24] = {m, 16'h0000};
			tspace[(s*3+t)*4 +: 4] = 4'hF;
			tmask[(s*3+(t+1)%3)*24 +: 24] = 24'hFF0000;
			tmatch[(s*3+(t+1)%3)*24 +: 24] = {m | 8'h80, 16'h0000};
			tspace[(s*3+(t+1)%3)*4 +: 4] = 4'h8;
			in_application_update = 1'b0;
			dec({m, 16'($urandom)}, 20'h00001 << s, 1'b0);
			dec({m | 8'h80, 16'($urandom)}, 20'h00000, 1'b0);
			in_application_update = 1'b1;
			dec({m | 8'h80, 16'($urandom)}, 20'h00001 << s, 1'b0);
		end
		cen = 1'b0;
		addr = 24'h000000;
		@(negedge clk);
		chk("freeze_sram", 0, rsel);
		cen = 1'b1;
		$display("decode test done");
		rb_en = 1'b1;
		prot = (20'($urandom) | 20'h80002) & ~20'h00021;
		@(negedge clk);
		chk("prot_status", prot, pstat);
		chk("oe", 1, oe);
		run(4'h1, 5'h00, 1'b0, PC);
		run(4'h1, 5'h05, 1'b0, PC);
		run(4'h1, 5'h01, 1'b1, 0);
		run(4'h2, 5'h13, 1'b1, 0);
		run(4'h1, 5'h1F, 1'b1, 0);
		run(4'h2, 5'h00, 1'b0, EC);
		$display("program and erase test done");
		i = low_cnt;
		u_host.issue(4'h2, 5'h05, 16'h0000);
		repeat (4) @(negedge clk);
		chk("busy", 1, busy);
		u_host.issue(4'h4, 5'h05, 16'h0000);
		@(negedge clk);
		chk("suspended", 1, susp);
		chk("pin_suspended", 1, pin);
		repeat (6) @(negedge clk);
		u_host.issue(4'h8, 5'h05, 16'h0000);
		@(negedge clk);
		chk("pin_resumed", 0, pin);
		for (t = 0; t < 300 && pin !== 1'b1; t++)
			@(negedge clk);
		// the edge that takes the suspend is still an erase cycle
		chk("erase_cycles", EC + 1, low_cnt - i);
		chk("notes_left", 0, q.size());
		$display("suspend test done");
		test_done();
	end
endmodule : mem_select_flash_status_tb
